/* File: src/psc_pstate_ctrl.v */
/*
  performance-state control and hardware-coordinated feedback counters for
  one logical processor, reached by model-register reads and writes.
  assumes a single 40 MHz clock, a one-cycle read or write strobe from the
  core, and sampling pulses for the reference and delivered rates.
*/
// Function
// - feature query reports performance-state support at bit 7.
// - transitions only when misc enable bit 16 set; bit clears on reset.
// - writing 16-bit target request starts a move toward that point.
// - request during a transition is kept and applied after it completes.
// - reading target request returns last requested point, not live point.
// - live operating point is shown in a status register, always current.
// - transitions are discrete steps; no sleep, no bus-master stall.
// - code meaning is implementation defined; invalid codes are not taken.
// - a one-cycle event pulse marks every completed transition.
// - power-management query bit 0 reads one: feedback counters present.
// - reference counter advances with a fixed boot-time rate.
// - actual counter advances with delivered performance.
// - counters advance only in the active executing state.
// - on either counter wrapping, both counters restart from zero.
// - each counter is 64-bit and writable alone.
`timescale 1ns/100ps
`include "psc_regs.vh"

module psc_pstate_ctrl
(
  input  wire        clock,
  input  wire        arst_n,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [15:0] reg_addr,
  input  wire [63:0] reg_wdata,
  output reg  [63:0] reg_rdata,
  output reg         reg_rvalid,
  input  wire        ref_tick,
  input  wire        act_tick,
  input  wire        active_executing_state,
  output wire [15:0] operating_point_now,
  output wire        transition_busy,
  output reg         transition_event
);

  ////////////////////////////////////////////////////////////////////////
  localparam ST_IDLE = 1'b0;
  localparam ST_STEP = 1'b1;

  reg  [1:0]  rst_sync_r;
  wire        rst_n;
  reg         state_r;
  reg  [15:0] request_r;
  reg         pending_r;
  reg  [15:0] op_now_r;
  reg  [15:0] step_target_r;
  reg  [15:0] step_cnt_r;
  reg         pstate_en_r;
  reg  [63:0] ref_cnt_r;
  reg  [63:0] act_cnt_r;
  reg  [63:0] ref_nxt;
  reg  [63:0] act_nxt;
  reg         ref_inc;
  reg         act_inc;
  reg  [15:0] request_nxt;
  reg         pending_nxt;
  reg  [15:0] op_now_nxt;
  reg  [15:0] step_target_nxt;
  reg  [15:0] step_cnt_nxt;
  reg         state_nxt;
  reg         event_nxt;
  reg  [63:0] rdata_nxt;

  // all codes with the top byte clear are taken as valid here
  function code_ok;
    input [15:0] code;
    begin
      code_ok = (code[15:8] == 8'h00);
    end
  endfunction

  function is_addr;
    input [15:0] a;
    input [15:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  wire wr_req = reg_wr && is_addr(reg_addr, `PSC_ADDR_TARGET_REQ);
  wire wr_misc = reg_wr && is_addr(reg_addr, `PSC_ADDR_MISC_EN);
  wire wr_ref = reg_wr && is_addr(reg_addr, `PSC_ADDR_REF_CNT);
  wire wr_act = reg_wr && is_addr(reg_addr, `PSC_ADDR_ACT_CNT);

  ////////////////////////////////////////////////////////////////////////
  // enable bit
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pstate_en_r <= 1'b0;
    else if (wr_misc)
      pstate_en_r <= reg_wdata[`PSC_MISC_PSTATE_EN_BIT];
  end

  ////////////////////////////////////////////////////////////////////////
  // request and transition sequencing, next-state logic
  always @*
  begin
    request_nxt     = request_r;
    pending_nxt     = pending_r;
    op_now_nxt      = op_now_r;
    step_target_nxt = step_target_r;
    step_cnt_nxt    = step_cnt_r;
    state_nxt       = state_r;
    event_nxt       = 1'b0;

    // a refused code leaves the last request untouched
    if (wr_req && code_ok(reg_wdata[15:0]))
    begin
      request_nxt = reg_wdata[15:0];
      pending_nxt = 1'b1;
    end

    case (state_r)
      ST_IDLE:
      begin
        // a new write in the same cycle is picked up next cycle,
        // so the set of the pending flag always wins over its clear
        if (pending_r && pstate_en_r && !wr_req)
        begin
          pending_nxt     = 1'b0;
          step_target_nxt = request_r;
          step_cnt_nxt    = 16'h0000;
          state_nxt       = ST_STEP;
        end
      end

      ST_STEP:
      begin
        // the core keeps running through the step, no stall
        if (step_cnt_r == (`PSC_STEP_CYC - 1))
        begin
          op_now_nxt = step_target_r;
          event_nxt  = 1'b1;
          state_nxt  = ST_IDLE;
        end
        else
        begin
          step_cnt_nxt = step_cnt_r + 16'h0001;
        end
      end

      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // request and transition sequencing, registers
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      request_r        <= `PSC_OP_RESET;
      pending_r        <= 1'b0;
      op_now_r         <= `PSC_OP_RESET;
      step_target_r    <= `PSC_OP_RESET;
      step_cnt_r       <= 16'h0000;
      state_r          <= ST_IDLE;
      transition_event <= 1'b0;
    end
    else
    begin
      request_r        <= request_nxt;
      pending_r        <= pending_nxt;
      op_now_r         <= op_now_nxt;
      step_target_r    <= step_target_nxt;
      step_cnt_r       <= step_cnt_nxt;
      state_r          <= state_nxt;
      transition_event <= event_nxt;
    end
  end

  assign operating_point_now = op_now_r;
  assign transition_busy = (state_r == ST_STEP);

  ////////////////////////////////////////////////////////////////////////
  // feedback counters
  always @*
  begin
    ref_inc = ref_tick && active_executing_state;
    act_inc = act_tick && active_executing_state;
    ref_nxt = ref_cnt_r + {63'h0, ref_inc};
    act_nxt = act_cnt_r + {63'h0, act_inc};
    // a wrap on either side clears both
    if ((ref_inc && (&ref_cnt_r)) || (act_inc && (&act_cnt_r)))
    begin
      ref_nxt = 64'h0000000000000000;
      act_nxt = 64'h0000000000000000;
    end
    // a software write wins for its own counter only
    if (wr_ref)
      ref_nxt = reg_wdata;
    if (wr_act)
      act_nxt = reg_wdata;
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_cnt_r <= 64'h0000000000000000;
      act_cnt_r <= 64'h0000000000000000;
    end
    else
    begin
      ref_cnt_r <= ref_nxt;
      act_cnt_r <= act_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data select; the word is held between reads
  always @*
  begin
    rdata_nxt = reg_rdata;
    if (!reg_rd)
      rdata_nxt = reg_rdata;
    else if (is_addr(reg_addr, `PSC_ADDR_REF_CNT))
      rdata_nxt = ref_cnt_r;
    else if (is_addr(reg_addr, `PSC_ADDR_ACT_CNT))
      rdata_nxt = act_cnt_r;
    else if (is_addr(reg_addr, `PSC_ADDR_TARGET_REQ))
      rdata_nxt = {48'h0, request_r};
    else if (is_addr(reg_addr, `PSC_ADDR_OP_NOW))
      rdata_nxt = {48'h0, op_now_r};
    else if (is_addr(reg_addr, `PSC_ADDR_MISC_EN))
      rdata_nxt = {47'h0, pstate_en_r, 16'h0000};
    else if (is_addr(reg_addr, `PSC_ADDR_FEAT_QUERY))
      rdata_nxt = 64'h0000000000000080;
    else if (is_addr(reg_addr, `PSC_ADDR_PM_QUERY))
      rdata_nxt = 64'h0000000000000001;
    else
      rdata_nxt = 64'h0000000000000000;
  end

  ////////////////////////////////////////////////////////////////////////
  // read answer, one cycle after the strobe
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata  <= 64'h0000000000000000;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      reg_rdata  <= rdata_nxt;
    end
  end

endmodule

/* File: src/psc_regs.vh */
/*
  register addresses, field positions, reset values and timing counts for
  the performance-state control and feedback counter block.
  assumes the includer uses these macros with a 16-bit register address.
*/
`ifndef PSC_REGS_VH
`define PSC_REGS_VH

// model-register addresses
`define PSC_ADDR_REF_CNT     16'h00E7
`define PSC_ADDR_ACT_CNT     16'h00E8
`define PSC_ADDR_TARGET_REQ  16'h0199
`define PSC_ADDR_OP_NOW      16'h0198
`define PSC_ADDR_MISC_EN     16'h01A0
`define PSC_ADDR_FEAT_QUERY  16'h0F01
`define PSC_ADDR_PM_QUERY    16'h0F06

// field positions
`define PSC_MISC_PSTATE_EN_BIT 16
`define PSC_FEAT_PSTATE_BIT    7
`define PSC_PM_FEEDBACK_BIT    0

// reset values
`define PSC_OP_RESET         16'h0000
`define PSC_MISC_EN_RESET    64'h0000000000000000

// settle time of one operating-point step, in ns, and as cycles at 40 MHz
`define PSC_CLK_NS           25
`define PSC_STEP_NS          1000
`define PSC_STEP_CYC         ((`PSC_STEP_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS)

`endif

/* File: verification/psc_chk_properties.sv */
/* port checker for the p-state block.
   assumes bind onto psc_pstate_ctrl, one clock. */
`timescale 1ns/100ps
`include "psc_regs.vh"
module psc_chk
(
  input wire        clock,
  input wire        arst_n,
  input wire        reg_rd,
  input wire [15:0] reg_addr,
  input wire [63:0] reg_rdata,
  input wire        reg_rvalid,
  input wire [15:0] operating_point_now,
  input wire        transition_busy,
  input wire        transition_event
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read got no answer");
  a_rvalid_quiet: assert property (!reg_rd |=> !reg_rvalid)
    else $error("answer without read");
  a_feature_bit: assert property (reg_rd &&
    reg_addr == `PSC_ADDR_FEAT_QUERY |=> reg_rdata == 64'h80)
    else $error("feature bit wrong");
  a_feedback_bit: assert property (reg_rd &&
    reg_addr == `PSC_ADDR_PM_QUERY |=> reg_rdata == 64'h1)
    else $error("feedback bit wrong");
  a_event_pulse: assert property (transition_event |=> !transition_event)
    else $error("event longer than one cycle");
  a_event_ends_step: assert property (transition_event |->
    !transition_busy && $past(transition_busy)) else $error("event off step");
  a_live_holds: assert property (!transition_event |->
    $stable(operating_point_now)) else $error("live point moved alone");
  a_step_time: assert property ($rose(transition_busy) |->
    transition_busy[*8] ##[30:34] transition_event)
    else $error("step length wrong");
  cover property (transition_event);
  cover property (reg_rd && reg_addr == `PSC_ADDR_REF_CNT);
  cover property (transition_busy && reg_rd);
endmodule
bind psc_pstate_ctrl psc_chk i_chk (.clock(clock), .arst_n(arst_n),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .operating_point_now(operating_point_now),
  .transition_busy(transition_busy), .transition_event(transition_event));

/* File: verification/psc_host.sv */
/* software side: model-register reads and writes.
   assumes one-cycle strobes driven at the falling edge. */
`timescale 1ns/100ps
module psc_host
(
  input  wire        clock,
  output reg         reg_wr,
  output reg         reg_rd,
  output reg  [15:0] reg_addr,
  output reg  [63:0] reg_wdata,
  input  wire [63:0] reg_rdata
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 64'h0;
  end
  task wr(input [15:0] a, input [63:0] d);
  begin
    @(negedge clock);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_wdata = ~d; // released data must not look still valid
  end
  endtask
  task rd(input [15:0] a, output [63:0] d);
  begin
    @(negedge clock);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_rd = 1'b0;
    d = reg_rdata;
  end
  endtask
endmodule

/* File: verification/tb.sv */
/* self-checking bench for psc_pstate_ctrl.
   assumes psc_host drives the register strobes. */
`timescale 1ns/100ps
`include "psc_regs.vh"
module tb;
  reg         clock;
  reg         arst_n;
  reg         rt;
  reg         at;
  reg         ex;
  wire        wr;
  wire        rd;
  wire        rv;
  wire        bz;
  wire        ev;
  wire [15:0] ad;
  wire [15:0] op;
  wire [63:0] wd;
  wire [63:0] rdt;
  reg  [63:0] v;
  reg  [63:0] s;
  integer     err_count;
  integer     num_checks;
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  psc_host i_host (.clock(clock), .reg_wr(wr), .reg_rd(rd), .reg_addr(ad),
    .reg_wdata(wd), .reg_rdata(rdt));
  psc_pstate_ctrl i_dut (.clock(clock), .arst_n(arst_n), .reg_wr(wr),
    .reg_rd(rd), .reg_addr(ad), .reg_wdata(wd), .reg_rdata(rdt),
    .reg_rvalid(rv), .ref_tick(rt), .act_tick(at),
    .active_executing_state(ex), .operating_point_now(op),
    .transition_busy(bz), .transition_event(ev));
  ////////////////////////////////////////////////////////////
  task chk(input [63:0] g, input [63:0] e);
  begin
    num_checks = num_checks + 1;
    if (g !== e)
    begin
      err_count = err_count + 1;
      $display("FAIL %0t got %h want %h", $time, g, e);
    end
  end
  endtask
  task tally_and_finish;
  begin
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  task wait_ev; // bounded: a lost step ends the run
    integer i;
  begin
    i = 0;
    @(posedge clock);
    #1;
    while (ev !== 1'b1 && i < 100)
    begin
      @(posedge clock);
      #1;
      i = i + 1;
    end
    if (i == 100)
    begin
      err_count = err_count + 1;
      tally_and_finish;
    end
  end
  endtask
  task t_ids;
  begin
    i_host.rd(`PSC_ADDR_MISC_EN, v); chk(v, 64'h0);
    chk(rv, 1'b1);
    i_host.rd(`PSC_ADDR_REF_CNT, v); chk(v, 64'h0);
  end
  endtask
  task t_steps;
  begin
    i_host.wr(`PSC_ADDR_TARGET_REQ, 64'h12);
    repeat (60) @(negedge clock);
    chk(op, 16'h0000);
    i_host.wr(`PSC_ADDR_MISC_EN, 64'h10000);
    wait_ev; chk(op, 16'h0012);
    chk(bz, 1'b0);
    i_host.wr(`PSC_ADDR_TARGET_REQ, 64'h34);
    @(negedge clock);
    chk(bz, 1'b1);
    i_host.wr(`PSC_ADDR_TARGET_REQ, 64'h56);
    i_host.rd(`PSC_ADDR_TARGET_REQ, v); chk(v, 64'h56);
    chk(op, 16'h0012);
    wait_ev; chk(op, 16'h0034);
    wait_ev; chk(op, 16'h0056);
  end
  endtask
  task t_refuse;
  begin
    i_host.wr(`PSC_ADDR_TARGET_REQ, 64'h100);
    i_host.rd(`PSC_ADDR_TARGET_REQ, v); chk(v, 64'h56);
    i_host.wr(`PSC_ADDR_OP_NOW, 64'h77);
    i_host.rd(`PSC_ADDR_OP_NOW, v); chk(v, 64'h56);
  end
  endtask
  task t_count; // ticks run gated by execution; act_tick also drops for two cycles, and act wraps
  begin
    i_host.wr(`PSC_ADDR_REF_CNT, 64'h5);
    i_host.wr(`PSC_ADDR_ACT_CNT, 64'hFFFFFFFFFFFFFFFE);
    @(negedge clock);
    ex = 1'b1;
    repeat (3) @(negedge clock);
    at = 1'b0;
    repeat (2) @(negedge clock);
    ex = 1'b0;
    i_host.rd(`PSC_ADDR_REF_CNT, v); chk(v, 64'h3);
    i_host.rd(`PSC_ADDR_ACT_CNT, v); chk(v, 64'h1);
    chk({63'h0, v < 64'hFFFFFFFFFFFFFFFE}, 64'h1);
    i_host.wr(`PSC_ADDR_REF_CNT, 64'h0);
    i_host.wr(`PSC_ADDR_ACT_CNT, 64'h0);
    @(negedge clock);
    ex = 1'b1;
    at = 1'b1;
    repeat (4) @(negedge clock);
    ex = 1'b0;
    i_host.rd(`PSC_ADDR_REF_CNT, s); chk(s, 64'h4);
    i_host.rd(`PSC_ADDR_ACT_CNT, v); chk(v, s);
  end
  endtask
  initial
  begin
    err_count = 0;
    num_checks = 0;
    arst_n = 1'b0;
    rt = 1'b1;
    at = 1'b1;
    ex = 1'b0;
    repeat (6) @(negedge clock);
    arst_n = 1'b1;
    repeat (3) @(negedge clock);
    t_ids;
    t_steps;
    t_refuse;
    t_count;
    tally_and_finish;
  end
endmodule
